// >>> hdl/comparator_defs.vh
// Purpose: Constants for the comparator control block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: Offsets are byte addresses
`ifndef COMPARATOR_DEFS_VH
`define COMPARATOR_DEFS_VH
// Register byte addresses
`define CFG_ADDR 12'hf90
`define CTRL_ADDR 12'hf94
`define STATUS_ADDR 12'hf98
`define MASK_ADDR 12'hf9c
`define ADDR_W 12
// Config register fields
`define CFG_RESET 8'h14
`define CFG_POS_SEL_BIT 7
`define CFG_NEG_SEL_BIT 6
`define CFG_LVL_HI 5
`define CFG_LVL_LO 2
`define CFG_FINE_HI 1
`define CFG_FINE_LO 0
// Control register fields
`define CTRL_RESET 8'h00
`define CTRL_PWR_DOWN_BIT 0
`define CTRL_SHARED_SEL_BIT 6
`define CTRL_OUT_EN_BIT 1
// Status and mask fields
`define ST_CHANGE_BIT 0
`define ST_RISE_BIT 1
`define ST_FALL_BIT 2
`define ST_W 3
`define ST_RESET 3'h0
`define MASK_RESET 3'h0
// Largest reference code on the coarse scale
`define LVL_MAX 4'h8
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hdl/level_sync.v
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Single clock aclk
// Notes: First stage feeds only the second
module level_sync (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Level
   input wire async_in,
   output reg sync_out
);
   reg meta_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // level_sync

// >>> hdl/hyst_latch.v
// Purpose: Holds the comparator level inside the hysteresis band
// Assumes: Analogue core flags above and below margin
// Notes: Cleared while powered down
module hyst_latch (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Analogue flags and power down
   input wire above,
   input wire below,
   input wire power_down,
   // Result
   output reg level
);
   always @(posedge aclk) begin
      if (!aresetn || power_down) begin
         level <= 1'b0;
      end else if (above && !below) begin
         level <= 1'b1;
      end else if (below && !above) begin
         level <= 1'b0;
      end
      // Neither flag: hold
   end
endmodule // hyst_latch

// >>> hdl/comparator_control.v
// Purpose: Register, routing and event logic around the comparator
// Assumes: AXI4-Lite slave, synchronous active-low reset, 200 MHz aclk
// Notes: Analogue flags arrive asynchronous and are synchronised here
`include "comparator_defs.vh"
module comparator_control #(
   parameter SMALL_PACKAGE = 0
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Analogue core
   input wire cmp_above,
   input wire cmp_below,
   output reg positive_source_select,
   output reg negative_source_select,
   output reg ref_enable,
   output reg [5:0] reference_level,
   output reg cmp_power_down,
   // Pins, shared interrupt and comparator interrupt
   input wire port_irq_pin,
   output reg cmp_out_pin,
   output reg shared_irq,
   output reg irq
);
   // Registers
   reg [7:0] comparator_config_q;
   reg [7:0] ctrl_q;
   reg [`ST_W-1:0] status_q;
   reg [`ST_W-1:0] mask_q;
   reg [11:0] waddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg have_aw_q;
   reg have_w_q;
   reg result_prev_q;
   wire level_raw;
   wire result;
   reg [7:0] cfg_wr;
   reg [`ST_W-1:0] events;
   reg [31:0] rd_word;
   reg rd_hit;
   wire wr_fire;
   wire wr_hit;

   // Hysteresis latch
   hyst_latch u_hyst (
      .aclk(aclk),
      .aresetn(aresetn),
      .above(cmp_above),
      .below(cmp_below),
      .power_down(ctrl_q[`CTRL_PWR_DOWN_BIT]),
      .level(level_raw)
   );

   // Into the bus clock domain
   level_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(level_raw),
      .sync_out(result)
   );

   // Write channel capture, either order
   assign wr_fire = have_aw_q && have_w_q && !s_axi_bvalid;
   assign wr_hit = (waddr_q == `CFG_ADDR) || (waddr_q == `CTRL_ADDR) ||
      (waddr_q == `STATUS_ADDR) || (waddr_q == `MASK_ADDR);

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         have_aw_q <= 1'b0;
         have_w_q <= 1'b0;
         waddr_q <= 12'h000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         s_axi_awready <= !have_aw_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !have_w_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            have_aw_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            have_w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Config write value; fine bits kept zero on larger packages
   always @* begin
      cfg_wr = wdata_q[7:0];
      if (SMALL_PACKAGE == 0) begin
         cfg_wr[`CFG_FINE_HI:`CFG_FINE_LO] = 2'b00;
      end
   end

   // Hardware events
   always @* begin
      events = {`ST_W{1'b0}};
      events[`ST_CHANGE_BIT] = result ^ result_prev_q;
      events[`ST_RISE_BIT] = result & ~result_prev_q;
      events[`ST_FALL_BIT] = ~result & result_prev_q;
   end

   // Register file
   always @(posedge aclk) begin
      if (!aresetn) begin
         comparator_config_q <= `CFG_RESET;
         ctrl_q <= `CTRL_RESET;
         mask_q <= `MASK_RESET;
         status_q <= `ST_RESET;
         result_prev_q <= 1'b0;
      end else begin
         result_prev_q <= result;
         if (wr_fire && wstrb_q[0]) begin
            if (waddr_q == `CFG_ADDR) begin
               comparator_config_q <= cfg_wr;
            end
            if (waddr_q == `CTRL_ADDR) begin
               ctrl_q <= wdata_q[7:0];
            end
            if (waddr_q == `MASK_ADDR) begin
               mask_q <= wdata_q[`ST_W-1:0];
            end
         end
         // Set wins over write-one-to-clear
         if (wr_fire && wstrb_q[0] && waddr_q == `STATUS_ADDR) begin
            status_q <= (status_q & ~wdata_q[`ST_W-1:0]) | events;
         end else begin
            status_q <= status_q | events;
         end
      end
   end

   // Read channel
   always @* begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `CFG_ADDR: rd_word[7:0] = comparator_config_q;
         `CTRL_ADDR: rd_word[7:0] = ctrl_q;
         `STATUS_ADDR: rd_word = {28'h0000000, result, status_q};
         `MASK_ADDR: rd_word[`ST_W-1:0] = mask_q;
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Analogue controls and outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         positive_source_select <= 1'b0;
         negative_source_select <= 1'b0;
         ref_enable <= 1'b0;
         reference_level <= 6'h00;
         cmp_power_down <= 1'b0;
         cmp_out_pin <= 1'b0;
         shared_irq <= 1'b0;
         irq <= 1'b0;
      end else begin
         positive_source_select <= comparator_config_q[`CFG_POS_SEL_BIT];
         negative_source_select <= comparator_config_q[`CFG_NEG_SEL_BIT];
         ref_enable <= comparator_config_q[`CFG_NEG_SEL_BIT];
         reference_level <= comparator_config_q[`CFG_LVL_HI:`CFG_FINE_LO];
         cmp_power_down <= ctrl_q[`CTRL_PWR_DOWN_BIT];
         cmp_out_pin <= ctrl_q[`CTRL_OUT_EN_BIT] & result;
         shared_irq <= ctrl_q[`CTRL_SHARED_SEL_BIT] ? result : port_irq_pin;
         irq <= |(status_q & mask_q);
      end
   end
endmodule // comparator_control

// >>> bench/comparator_control_assertions.sv
// Purpose: Port checks for comparator_control
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance
module comparator_checks #(
   parameter SMALL_PACKAGE = 0
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_wvalid,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire cmp_above,
   input wire cmp_below,
   input wire negative_source_select,
   input wire ref_enable,
   input wire [5:0] reference_level,
   input wire cmp_power_down,
   input wire cmp_out_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_low;
      (cmp_below && !cmp_above)[*6];
   endsequence
   sequence s_off;
      cmp_power_down[*6];
   endsequence
   AST_LOW_PIN: assert property (s_low |-> !cmp_out_pin)
      else $error("pin high after negative lead");
   AST_OFF_PIN: assert property (s_off |-> !cmp_out_pin)
      else $error("pin high while powered down");
   AST_REF_PAIR: assert property (ref_enable == negative_source_select)
      else $error("reference enable differs from select");
   AST_FINE_ZERO: assert property (SMALL_PACKAGE != 0 || reference_level[1:0] == 2'h0)
      else $error("fine bits set on large package");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_B_CAUSE: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid || s_axi_wvalid, 2))
      else $error("response without request");
   AST_R_LAT: assert property ($rose(s_axi_arready) |=> s_axi_rvalid)
      else $error("read data late");
endmodule // comparator_checks
bind comparator_control comparator_checks #(.SMALL_PACKAGE(SMALL_PACKAGE)) u_chk (.*);

// >>> bench/comparator_control_test.sv
// Purpose: Self-checking bench for comparator_control
// Assumes: AXI4-Lite master tasks, LFSR stimulus
// Notes: SMALL_PACKAGE left at 0
`include "comparator_defs.vh"
module comparator_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic cmp_above, cmp_below, port_irq_pin, positive_source_select, negative_source_select;
   logic ref_enable, cmp_power_down, cmp_out_pin, shared_irq, irq, lev;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb;
   logic [5:0] reference_level;
   logic [7:0] cfg;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
   int n_mismatch, tests_run, v;
   comparator_control u_dut (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rresp, er);
      if (er == `RESP_OKAY) chk(s_axi_rdata, {24'h0, exp});
   endtask
   // Flags held for n cycles; model level follows the leading input
   task automatic drive(input logic a, input logic b, input int n);
      @(posedge aclk);
      cmp_above <= a;
      cmp_below <= b;
      if (a != b) lev = a;
      repeat (n) @(posedge aclk);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   initial begin
      #50000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {cmp_above, cmp_below, port_irq_pin, lev} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      rnd = 32'h023d1af4;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`CFG_ADDR, `CFG_RESET, `RESP_OKAY);
      rd(`STATUS_ADDR, 8'h00, `RESP_OKAY);
      $display("reset test done");
      for (v = 0; v < 9; v++) begin
         rnd = lfsr(rnd);
         cfg = {rnd[7:6], v[3:0], rnd[1:0]};
         wr(`CFG_ADDR, cfg, `RESP_OKAY);
         cfg[1:0] = 2'h0;
         rd(`CFG_ADDR, cfg, `RESP_OKAY);
         chk(positive_source_select, cfg[7]);
         chk({negative_source_select, ref_enable}, {2{cfg[6]}});
         chk(reference_level, cfg[5:0]);
      end
      wr(12'h000, 8'hff, `RESP_SLVERR);
      rd(12'h000, 8'h00, `RESP_SLVERR);
      $display("config test done");
      wr(`CTRL_ADDR, 8'h02, `RESP_OKAY);
      port_irq_pin <= rnd[9];
      repeat (3) @(posedge aclk);
      chk(shared_irq, rnd[9]);
      wr(`CTRL_ADDR, 8'h42, `RESP_OKAY);
      wr(`MASK_ADDR, 8'h07, `RESP_OKAY);
      drive(1'b1, 1'b0, 8);
      chk({cmp_out_pin, shared_irq, irq}, {lev, lev, 1'b1});
      rd(`STATUS_ADDR, 8'h0b, `RESP_OKAY);
      drive(1'b0, 1'b0, 8);
      chk(cmp_out_pin, lev);
      wr(`STATUS_ADDR, 8'h03, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(`MASK_ADDR, 8'h00, `RESP_OKAY);
      drive(1'b0, 1'b1, 8);
      chk({cmp_out_pin, shared_irq, irq}, {lev, lev, 1'b0});
      rd(`STATUS_ADDR, 8'h05, `RESP_OKAY);
      wr(`STATUS_ADDR, 8'h07, `RESP_OKAY);
      $display("result test done");
      wr(`CTRL_ADDR, 8'h43, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      wr(`STATUS_ADDR, 8'h07, `RESP_OKAY);
      lev = 1'b0;
      drive(1'b1, 1'b0, 8);
      lev = 1'b0;
      chk({cmp_power_down, cmp_out_pin}, {1'b1, lev});
      rd(`STATUS_ADDR, 8'h00, `RESP_OKAY);
      $display("power test done");
      tally_and_finish();
   end
endmodule // comparator_control_test
